// [hw/brc_pkg.sv]
// constants for the regulator control register bank
package brc_pkg;
  // register offsets
  localparam logic [7:0] OFS_SETPOINT = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h01;
  localparam logic [7:0] OFS_CTRL2 = 8'h02;
  localparam logic [7:0] OFS_CTRL3 = 8'h03;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  // first control register fields
  localparam int unsigned C1_RESET_BIT = 7;
  localparam int unsigned C1_SSC_BIT = 6;
  localparam int unsigned C1_SW_BIT = 5;
  localparam int unsigned C1_FPWM_BIT = 4;
  localparam int unsigned C1_DISCH_BIT = 3;
  localparam int unsigned C1_HICCUP_BIT = 2;
  localparam int unsigned C1_RAMP_LSB = 0;
  // second and third control register fields
  localparam int unsigned C2_RANGE_LSB = 2;
  localparam int unsigned C2_SST_LSB = 0;
  localparam int unsigned C3_SINGLE_BIT = 1;
  localparam int unsigned C3_PGBLNK_BIT = 0;
  // reset values and writable masks
  localparam logic [7:0] CTRL1_RESET = 8'h2a;
  localparam logic [7:0] CTRL1_MASK = 8'h7f;
  localparam logic [7:0] CTRL2_RESET = 8'h09;
  localparam logic [7:0] CTRL2_MASK = 8'h0f;
  localparam logic [7:0] CTRL3_RESET = 8'h00;
  localparam logic [7:0] CTRL3_MASK = 8'h03;
  localparam logic [7:0] STATUS_RESET = 8'h02;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // retention threshold, handled by an analog comparator outside
  localparam int unsigned RETENTION_MV = 1400;
  // setpoint arithmetic in microvolts
  localparam int unsigned TARGET_W = 22;
  localparam logic [21:0] BASE_LOW_UV = 22'h061a80;
  localparam logic [21:0] BASE_HIGH_UV = 22'h0c3500;
  localparam logic [21:0] STEP_R0_UV = 22'h0004e2;
  localparam logic [21:0] STEP_R1_UV = 22'h0009c4;
  localparam logic [21:0] STEP_R2_UV = 22'h001388;
  localparam logic [21:0] STEP_R3_UV = 22'h002710;
  // slew rates in microvolts per microsecond
  localparam int unsigned RAMP_W = 14;
  localparam logic [13:0] RAMP_SEL0_UV = 14'h2710;
  localparam logic [13:0] RAMP_SEL1_UV = 14'h1388;
  localparam logic [13:0] RAMP_SEL2_UV = 14'h04e2;
  localparam logic [13:0] RAMP_SEL3_UV = 14'h01f4;
  // serial target
  localparam int unsigned BITS_PER_BYTE = 8;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_REG, ST_WR, ST_RD
  } brc_state_type;
endpackage

// [hw/brc_sync2.sv]
// two flip-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
module brc_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  if (WIDTH < 1) begin : g_bad_width
    $error("brc_sync2 needs WIDTH of at least 1");
  end

  // first stage feeds only the second stage
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule // brc_sync2

// [hw/brc_setpoint.sv]
// converts setpoint code, range and slew select to microvolt figures
`timescale 1ns/1ps
module brc_setpoint import brc_pkg::*; (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] setpoint_code,
  input wire logic [1:0] voltage_range,
  input wire logic [1:0] ramp_rate_select,
  output logic [TARGET_W-1:0] target_uv,
  output logic [RAMP_W-1:0] ramp_uv_per_us
);
  logic [TARGET_W-1:0] target_reg;
  logic [TARGET_W-1:0] target_next;
  logic [RAMP_W-1:0] ramp_reg;
  logic [RAMP_W-1:0] ramp_next;
  logic [TARGET_W-1:0] base_uv;
  logic [TARGET_W-1:0] step_uv;

  always_comb begin
    base_uv = BASE_LOW_UV;
    case (voltage_range)
      2'h0: step_uv = STEP_R0_UV;
      2'h1: step_uv = STEP_R1_UV;
      2'h2: step_uv = STEP_R2_UV;
      default: begin
        step_uv = STEP_R3_UV;
        base_uv = BASE_HIGH_UV;
      end
    endcase
    // widest case 3.35 V still fits the 22-bit product
    target_next = base_uv + TARGET_W'(setpoint_code) * step_uv;
    case (ramp_rate_select)
      2'h0: ramp_next = RAMP_SEL0_UV;
      2'h1: ramp_next = RAMP_SEL1_UV;
      2'h2: ramp_next = RAMP_SEL2_UV;
      default: ramp_next = RAMP_SEL3_UV;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      target_reg <= '0;
      ramp_reg <= '0;
    end else begin
      target_reg <= target_next;
      ramp_reg <= ramp_next;
    end
  end

  assign target_uv = target_reg;
  assign ramp_uv_per_us = ramp_reg;
endmodule // brc_setpoint

// [hw/brc_regs.sv]
// serial target and register bank of the step-down regulator
`timescale 1ns/1ps
// Functional notes
// - supply below retention level returns every register to default
// - writing one to self-reset restores defaults and starts up afresh
// - self-reset bit always reads as zero
// - registers exist only at offsets 0 to 4; others are reserved
// - target is 0.4 V plus code times step, range 4 from 0.8 V
// - setpoint reset value comes from the strap pin at power-up
// - spread spectrum only while its bit is one; resets to zero
// - clearing switching bit stops switching, keeps registers, resets to one
// - forced PWM when bit set, mode pin high or sync clock present
// - output discharge only while its bit is one; resets to one
// - hiccup only when its bit is one; resets zero; not when stacked (here the bit is obeyed as written)
// - two-bit slew select gives 10, 5, 1.25, 0.5 mV/us, resets 1.25
// - first control register sits at offset 1 and resets to 2Ah
// - on mode needs enable pin, switching bit, no shutdown, no lockout
// - reads outside the map return 00h
// - written byte commits on the falling edge ending its acknowledge
module brc_regs import brc_pkg::*; #(
  parameter logic [4:0] TARGET_ADDR_HIGH = 5'h10,
  parameter logic [7:0] SETPOINT_STRAP0 = 8'h00,
  parameter logic [7:0] SETPOINT_STRAP1 = 8'h40,
  parameter logic [7:0] SETPOINT_STRAP2 = 8'h80,
  parameter logic [7:0] SETPOINT_STRAP3 = 8'hc0
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic supply_below_retention,
  input wire logic enable_pin,
  input wire logic thermal_shutdown,
  input wire logic overvoltage_lockout,
  input wire logic mode_pin_high,
  input wire logic mode_sync_clock,
  input wire logic [1:0] start_voltage_select_pin,
  input wire logic event_hiccup,
  input wire logic event_current_limit,
  input wire logic event_thermal_warning,
  input wire logic event_thermal_shutdown,
  input wire logic event_power_bad_under,
  input wire logic event_power_bad_over,
  output logic switching_on,
  output logic spread_spectrum_on,
  output logic forced_pwm_on,
  output logic discharge_on,
  output logic hiccup_on,
  output logic [1:0] ramp_rate_select,
  output logic [1:0] voltage_range,
  output logic [1:0] soft_start_time,
  output logic single_operation,
  output logic power_good_blanking,
  output logic [7:0] setpoint_code,
  output logic [TARGET_W-1:0] target_uv,
  output logic [RAMP_W-1:0] ramp_uv_per_us,
  output logic startup_request
);
  localparam int unsigned SYNC_W = 16;

  logic [SYNC_W-1:0] pins_sync;
  logic scl_s;
  logic sda_s;
  logic retention_low;
  logic enable_s;
  logic tshut_s;
  logic overvoltage_lockout_s;
  logic mode_high_s;
  logic mode_sync_s;
  logic [1:0] strap_s;
  logic [5:0] events_s;

  brc_sync2 #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clock(clock),
    .rstn(rstn),
    .async_in({event_hiccup, event_current_limit, event_thermal_warning,
               event_thermal_shutdown, event_power_bad_under, event_power_bad_over,
               start_voltage_select_pin, mode_sync_clock, mode_pin_high,
               overvoltage_lockout, thermal_shutdown, enable_pin,
               supply_below_retention, sda_in, scl_in}),
    .sync_out(pins_sync)
  );

  assign scl_s = pins_sync[0];
  assign sda_s = pins_sync[1];
  assign retention_low = pins_sync[2];
  assign enable_s = pins_sync[3];
  assign tshut_s = pins_sync[4];
  assign overvoltage_lockout_s = pins_sync[5];
  assign mode_high_s = pins_sync[6];
  assign mode_sync_s = pins_sync[7];
  assign strap_s = pins_sync[9:8];
  assign events_s = pins_sync[15:10];

  // register state
  logic [7:0] setpoint_reg, setpoint_next;
  logic [7:0] ctrl1_reg, ctrl1_next;
  logic [7:0] ctrl2_reg, ctrl2_next;
  logic [7:0] ctrl3_reg, ctrl3_next;
  logic [7:0] status_reg, status_next;
  logic [1:0] strap_reg, strap_next;
  logic [1:0] strap_done_reg, strap_done_next;
  logic startup_reg, startup_next;
  logic switching_reg, switching_next;

  // serial target state
  brc_state_type state_reg, state_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic ack_phase_reg, ack_phase_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] rd_shift_reg, rd_shift_next;
  logic [7:0] ptr_reg, ptr_next;
  logic drive_low_reg, drive_low_next;
  logic rw_reg, rw_next;
  logic nack_reg, nack_next;
  logic scl_prev_reg, sda_prev_reg;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  logic wr_commit, status_read;
  logic [7:0] rd_byte;

  // read view of the map; unmapped offsets read zero
  function automatic logic [7:0] read_map(input logic [7:0] ofs);
    case (ofs)
      OFS_SETPOINT: read_map = setpoint_reg;
      OFS_CTRL1: read_map = ctrl1_reg & CTRL1_MASK;
      OFS_CTRL2: read_map = ctrl2_reg & CTRL2_MASK;
      OFS_CTRL3: read_map = ctrl3_reg & CTRL3_MASK;
      OFS_STATUS: read_map = status_reg;
      default: read_map = UNMAPPED_READ;
    endcase
  endfunction

  function automatic logic [7:0] strap_setpoint(input logic [1:0] s);
    case (s)
      2'h0: strap_setpoint = SETPOINT_STRAP0;
      2'h1: strap_setpoint = SETPOINT_STRAP1;
      2'h2: strap_setpoint = SETPOINT_STRAP2;
      default: strap_setpoint = SETPOINT_STRAP3;
    endcase
  endfunction

  assign scl_rise = scl_s & ~scl_prev_reg;
  assign scl_fall = ~scl_s & scl_prev_reg;
  assign start_cond = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  assign stop_cond = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    ack_phase_next = ack_phase_reg;
    shift_next = shift_reg;
    rd_shift_next = rd_shift_reg;
    ptr_next = ptr_reg;
    drive_low_next = drive_low_reg;
    rw_next = rw_reg;
    nack_next = nack_reg;
    wr_commit = 1'b0;
    status_read = 1'b0;
    rd_byte = read_map(ptr_reg);
    if (retention_low) begin
      state_next = ST_IDLE;
      drive_low_next = 1'b0;
    end else if (start_cond) begin
      state_next = ST_ADDR;
      bit_cnt_next = 4'h0;
      ack_phase_next = 1'b0;
      drive_low_next = 1'b0;
    end else if (stop_cond) begin
      state_next = ST_IDLE;
      drive_low_next = 1'b0;
    end else if (state_reg != ST_IDLE) begin
      if (scl_rise) begin
        if (!ack_phase_reg && bit_cnt_reg < ACK_SLOT) begin
          shift_next = {shift_reg[6:0], sda_s};
          bit_cnt_next = bit_cnt_reg + 4'h1;
        end else if (ack_phase_reg && state_reg == ST_RD) begin
          nack_next = sda_s;
        end
      end else if (scl_fall) begin
        if (!ack_phase_reg && bit_cnt_reg == ACK_SLOT) begin
          ack_phase_next = 1'b1;
          drive_low_next = 1'b0;
          case (state_reg)
            ST_ADDR: begin
              rw_next = shift_reg[0];
              if (shift_reg[7:1] == {TARGET_ADDR_HIGH, strap_reg}) begin
                drive_low_next = 1'b1;
              end else begin
                state_next = ST_IDLE;
              end
            end
            ST_REG: drive_low_next = 1'b1;
            ST_WR: drive_low_next = 1'b1;
            default: drive_low_next = 1'b0;
          endcase
        end else if (ack_phase_reg) begin
          ack_phase_next = 1'b0;
          bit_cnt_next = 4'h0;
          drive_low_next = 1'b0;
          case (state_reg)
            ST_ADDR: begin
              if (rw_reg) begin
                state_next = ST_RD;
                rd_shift_next = rd_byte;
                drive_low_next = ~rd_byte[7];
                status_read = (ptr_reg == OFS_STATUS);
              end else begin
                state_next = ST_REG;
              end
            end
            ST_REG: begin
              ptr_next = shift_reg;
              state_next = ST_WR;
            end
            ST_WR: begin
              // commit as the acknowledge clock falls
              wr_commit = 1'b1;
              ptr_next = ptr_reg + 8'h01;
            end
            ST_RD: begin
              if (nack_reg) begin
                state_next = ST_IDLE;
              end else begin
                // pointer advances only once the byte was acknowledged
                ptr_next = ptr_reg + 8'h01;
                rd_shift_next = read_map(ptr_reg + 8'h01);
                drive_low_next = ~rd_shift_next[7];
                status_read = (ptr_reg + 8'h01 == OFS_STATUS);
              end
            end
            default: state_next = ST_IDLE;
          endcase
        end else if (state_reg == ST_RD && bit_cnt_reg != 4'h0) begin
          rd_shift_next = {rd_shift_reg[6:0], 1'b0};
          drive_low_next = ~rd_shift_next[7];
        end else if (state_reg == ST_RD) begin
          drive_low_next = ~rd_shift_reg[7];
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      ack_phase_reg <= 1'b0;
      shift_reg <= 8'h00;
      rd_shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      drive_low_reg <= 1'b0;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      ack_phase_reg <= ack_phase_next;
      shift_reg <= shift_next;
      rd_shift_reg <= rd_shift_next;
      ptr_reg <= ptr_next;
      drive_low_reg <= drive_low_next;
      rw_reg <= rw_next;
      nack_reg <= nack_next;
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  always_comb begin
    setpoint_next = setpoint_reg;
    ctrl1_next = ctrl1_reg;
    ctrl2_next = ctrl2_reg;
    ctrl3_next = ctrl3_reg;
    strap_next = strap_reg;
    strap_done_next = strap_done_reg;
    startup_next = 1'b0;
    // read clears the flags, but an event in the same cycle still lands
    status_next = (status_read ? 8'h00 : status_reg) | {2'b00, events_s};
    if (retention_low) begin
      // strap is caught again once the supply returns
      setpoint_next = 8'h00;
      ctrl1_next = CTRL1_RESET;
      ctrl2_next = CTRL2_RESET;
      ctrl3_next = CTRL3_RESET;
      status_next = STATUS_RESET;
      strap_done_next = 2'h2;
    end else if (strap_done_reg != 2'h3) begin
      strap_next = strap_s;
      setpoint_next = strap_setpoint(strap_s);
      strap_done_next = strap_done_reg + 2'h1;
      startup_next = (strap_done_reg == 2'h2);
    end else if (wr_commit) begin
      case (ptr_reg)
        OFS_SETPOINT: setpoint_next = shift_reg;
        OFS_CTRL1: begin
          if (shift_reg[C1_RESET_BIT]) begin
            // defaults from the strap held since power-up
            setpoint_next = strap_setpoint(strap_reg);
            ctrl1_next = CTRL1_RESET;
            ctrl2_next = CTRL2_RESET;
            ctrl3_next = CTRL3_RESET;
            status_next = STATUS_RESET | {2'b00, events_s};
            startup_next = 1'b1;
          end else begin
            ctrl1_next = shift_reg & CTRL1_MASK;
          end
        end
        OFS_CTRL2: ctrl2_next = shift_reg & CTRL2_MASK;
        OFS_CTRL3: ctrl3_next = shift_reg & CTRL3_MASK;
        default: setpoint_next = setpoint_reg;
      endcase
    end
    switching_next = (&strap_done_reg) & enable_s & ctrl1_reg[C1_SW_BIT]
                     & ~tshut_s & ~overvoltage_lockout_s;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      setpoint_reg <= 8'h00;
      ctrl1_reg <= CTRL1_RESET;
      ctrl2_reg <= CTRL2_RESET;
      ctrl3_reg <= CTRL3_RESET;
      status_reg <= STATUS_RESET;
      strap_reg <= 2'h0;
      strap_done_reg <= 2'h0;
      startup_reg <= 1'b0;
      switching_reg <= 1'b0;
    end else begin
      setpoint_reg <= setpoint_next;
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
      ctrl3_reg <= ctrl3_next;
      status_reg <= status_next;
      strap_reg <= strap_next;
      strap_done_reg <= strap_done_next;
      startup_reg <= startup_next;
      switching_reg <= switching_next;
    end
  end

  brc_setpoint u_setpoint (
    .clock(clock),
    .rstn(rstn),
    .setpoint_code(setpoint_reg),
    .voltage_range(ctrl2_reg[C2_RANGE_LSB +: 2]),
    .ramp_rate_select(ctrl1_reg[C1_RAMP_LSB +: 2]),
    .target_uv(target_uv),
    .ramp_uv_per_us(ramp_uv_per_us)
  );

  // open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_n = ~drive_low_reg;
  // no enable delay on resume: switching follows the bit directly
  assign switching_on = switching_reg;
  assign spread_spectrum_on = ctrl1_reg[C1_SSC_BIT];
  assign forced_pwm_on = ctrl1_reg[C1_FPWM_BIT] | mode_high_s | mode_sync_s;
  assign discharge_on = ctrl1_reg[C1_DISCH_BIT];
  // stacked use is the controller's concern; the bit is obeyed as written
  assign hiccup_on = ctrl1_reg[C1_HICCUP_BIT];
  assign ramp_rate_select = ctrl1_reg[C1_RAMP_LSB +: 2];
  assign voltage_range = ctrl2_reg[C2_RANGE_LSB +: 2];
  assign soft_start_time = ctrl2_reg[C2_SST_LSB +: 2];
  assign single_operation = ctrl3_reg[C3_SINGLE_BIT];
  assign power_good_blanking = ctrl3_reg[C3_PGBLNK_BIT];
  assign setpoint_code = setpoint_reg;
  // fresh start-up; controller holds off writes for the enable delay
  assign startup_request = startup_reg;
endmodule // brc_regs

// [bench/brc_regs_assertions.sv]
// assertion checker on the register bank ports
`timescale 1ns/1ps
module brc_regs_checker (
  input wire logic clock,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_oe_n,
  input wire logic supply_below_retention,
  input wire logic enable_pin,
  input wire logic thermal_shutdown,
  input wire logic overvoltage_lockout,
  input wire logic mode_pin_high,
  input wire logic mode_sync_clock,
  input wire logic switching_on,
  input wire logic spread_spectrum_on,
  input wire logic forced_pwm_on,
  input wire logic discharge_on,
  input wire logic hiccup_on,
  input wire logic [1:0] ramp_rate_select,
  input wire logic [1:0] voltage_range,
  input wire logic [7:0] setpoint_code,
  input wire logic [21:0] target_uv,
  input wire logic [13:0] ramp_uv_per_us,
  input wire logic startup_request
);
  localparam logic [13:0] RAMP_TBL [4] = '{14'h2710, 14'h1388, 14'h04e2, 14'h01f4};
  localparam logic [21:0] STEP_TBL [4] = '{22'h0004e2, 22'h0009c4, 22'h001388, 22'h002710};
  // edges since reset; registered figures hold reset junk for the first edge
  logic [1:0] age_reg;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) age_reg <= 2'h0;
    else if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // five samples cover the two-stage synchroniser plus the output register
  sequence off_held;
    (!enable_pin || thermal_shutdown || overvoltage_lockout) [*5];
  endsequence
  sequence mode_held;
    (mode_pin_high || mode_sync_clock) [*5];
  endsequence
  ramp_map_a: assert property (
    age_reg >= 2'h2 && $stable(ramp_rate_select) |-> ramp_uv_per_us == RAMP_TBL[ramp_rate_select])
    else $error("slew figure does not follow select");
  target_map_a: assert property (
    age_reg >= 2'h2 && $stable(setpoint_code) && $stable(voltage_range) |-> target_uv ==
    (voltage_range == 2'h3 ? 22'h0c3500 : 22'h061a80) + setpoint_code * STEP_TBL[voltage_range])
    else $error("target does not follow code and range");
  fpwm_pin_a: assert property (mode_held |-> forced_pwm_on)
    else $error("mode pin did not force pwm");
  off_hold_a: assert property (off_held |-> !switching_on)
    else $error("switching while a blocking condition holds");
  pulse_once_a: assert property (startup_request |=> !startup_request)
    else $error("start-up request longer than one cycle");
  boot_start_a: assert property (age_reg == 2'h1 |-> ##[0:3] startup_request)
    else $error("no start-up after reset");
  retain_dflt_a: assert property (
    supply_below_retention [*6] |-> discharge_on && !spread_spectrum_on && !hiccup_on
    && ramp_rate_select == 2'h2) else $error("controls not at default in low supply");
  sda_change_a: assert property (
    $changed(sda_oe_n) |-> !scl_in && !$past(scl_in))
    else $error("data line moved while clock high");
endmodule // brc_regs_checker
bind brc_regs brc_regs_checker chk_i (.clock(clock), .rstn(rstn), .scl_in(scl_in),
  .sda_oe_n(sda_oe_n), .supply_below_retention(supply_below_retention),
  .enable_pin(enable_pin), .thermal_shutdown(thermal_shutdown),
  .overvoltage_lockout(overvoltage_lockout), .mode_pin_high(mode_pin_high),
  .mode_sync_clock(mode_sync_clock), .switching_on(switching_on),
  .spread_spectrum_on(spread_spectrum_on), .forced_pwm_on(forced_pwm_on),
  .discharge_on(discharge_on), .hiccup_on(hiccup_on), .ramp_rate_select(ramp_rate_select),
  .voltage_range(voltage_range), .setpoint_code(setpoint_code), .target_uv(target_uv),
  .ramp_uv_per_us(ramp_uv_per_us), .startup_request(startup_request));

// [bench/brc_host_model.sv]
// behavioural serial bus controller facing the register bank
`timescale 1ns/1ps
module brc_host_model (
  input wire logic clock,
  input wire logic sda_bus,
  output logic scl,
  output logic sda_drv,
  output logic rd_valid,
  output logic [7:0] rd_data
);
  initial begin
    {scl, sda_drv, rd_valid} = 3'h6;
    rd_data = 8'h00;
  end
  // five clocks a phase keeps clear of the four-clock minimum
  task automatic half();
    repeat (5) @(negedge clock);
  endtask
  // data moves mid low phase, never near a clock edge, so no false start or stop
  task automatic bit_io(input logic b, output logic s);
    half();
    sda_drv = b;
    half();
    scl = 1'b1;
    half();
    s = sda_bus;
    scl = 1'b0;
  endtask
  task automatic start();
    half();
    sda_drv = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b0;
    half();
    scl = 1'b0;
  endtask
  task automatic stop();
    half();
    sda_drv = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b1;
    half();
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack_out, output logic [7:0] rx,
                      output logic ack_in);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(ack_out, ack_in);
  endtask
  task automatic rd_byte(input logic last);
    logic [7:0] rx;
    logic a;
    xfer(8'hff, last, rx, a);
    rd_data = rx;
    rd_valid = 1'b1;
    @(negedge clock);
    rd_valid = 1'b0;
  endtask
endmodule // brc_host_model

// [bench/tb.sv]
// self-checking bench for the regulator register bank
`timescale 1ns/1ps
module tb;
  localparam logic [13:0] RAMP_TBL [4] = '{14'h2710, 14'h1388, 14'h04e2, 14'h01f4};
  localparam logic [21:0] STEP_TBL [4] = '{22'h0004e2, 22'h0009c4, 22'h001388, 22'h002710};
  logic clock, rstn, scl, sda_drv, sda_bus, sda_out, sda_oe_n, rd_valid, sup_low, en_pin;
  logic tshut, ov_lock, mode_hi, mode_sync, sw_on, ssc_on, fpwm_on, dis_on, hic_on;
  logic single_op, pg_blank, start_req;
  logic [1:0] strap, ramp_sel, vrange, sst;
  logic [5:0] ev;
  logic [7:0] rd_data, sp_code;
  logic [21:0] tgt_uv;
  logic [13:0] ramp_uv;
  logic [6:0] dev_addr;
  logic [31:0] rnd;
  logic [7:0] exp_q[$];
  int n_errors = 0, total_checks = 0, n_start = 0;
  // pull-up on the data line: a released line reads high
  assign sda_bus = sda_drv & (sda_oe_n | sda_out);
  brc_regs uut (.clock(clock), .rstn(rstn), .scl_in(scl), .sda_in(sda_bus),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .supply_below_retention(sup_low),
    .enable_pin(en_pin), .thermal_shutdown(tshut), .overvoltage_lockout(ov_lock),
    .mode_pin_high(mode_hi), .mode_sync_clock(mode_sync), .start_voltage_select_pin(strap),
    .event_hiccup(ev[5]), .event_current_limit(ev[4]), .event_thermal_warning(ev[3]),
    .event_thermal_shutdown(ev[2]), .event_power_bad_under(ev[1]),
    .event_power_bad_over(ev[0]), .switching_on(sw_on), .spread_spectrum_on(ssc_on),
    .forced_pwm_on(fpwm_on), .discharge_on(dis_on), .hiccup_on(hic_on),
    .ramp_rate_select(ramp_sel), .voltage_range(vrange), .soft_start_time(sst),
    .single_operation(single_op), .power_good_blanking(pg_blank), .setpoint_code(sp_code),
    .target_uv(tgt_uv), .ramp_uv_per_us(ramp_uv), .startup_request(start_req));
  brc_host_model host (.clock(clock), .sda_bus(sda_bus), .scl(scl), .sda_drv(sda_drv),
    .rd_valid(rd_valid), .rd_data(rd_data));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic [7:0] rx;
    logic a0, a1, a2;
    host.start();
    host.xfer({dev_addr, 1'b0}, 1'b1, rx, a0);
    host.xfer(ofs, 1'b1, rx, a1);
    host.xfer(d, 1'b1, rx, a2);
    host.stop();
    chk({a0, a1, a2}, 32'h0);
  endtask
  // reads n bytes from ofs upward
  task automatic rd(input logic [7:0] ofs, input int n);
    logic [7:0] rx;
    logic a0, a1, a2;
    host.start();
    host.xfer({dev_addr, 1'b0}, 1'b1, rx, a0);
    host.xfer(ofs, 1'b1, rx, a1);
    host.start();
    host.xfer({dev_addr, 1'b1}, 1'b1, rx, a2);
    chk({a0, a1, a2}, 32'h0);
    for (int i = 0; i < n; i++) host.rd_byte(i == n - 1);
    host.stop();
  endtask
  task automatic dflt(input logic [7:0] sp);
    exp_q = '{sp, 8'h2a, 8'h09, 8'h00, 8'h02};
    rd(8'h00, 5);
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (40000) @(posedge clock);
    n_errors++;
    end_of_test();
  end
  always @(posedge clock) begin
    if (start_req === 1'b1) n_start++;
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk({24'h0, rd_data}, 32'h100);
      else chk({24'h0, rd_data}, {24'h0, exp_q.pop_front()});
    end
  end
  initial begin
    logic [7:0] v;
    int n0;
    {rstn, sup_low, en_pin, tshut, ov_lock, mode_hi, mode_sync} = 7'h10;
    {strap, ev, rnd, dev_addr} = {2'h1, 6'h00, 32'h90e9, 7'h41};
    repeat (5) @(negedge clock);
    rstn = 1'b1;
    repeat (5) @(negedge clock);
    chk(n_start, 1);
    chk({ssc_on, fpwm_on, dis_on, hic_on, ramp_sel, sw_on, sst, single_op, pg_blank},
        11'h154);
    dflt(8'h40);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      v = {1'b0, rnd[6:2], i[1:0]};
      wr(8'h01, v);
      exp_q.push_back(v);
      rd(8'h01, 1);
      chk({ssc_on, fpwm_on, dis_on, hic_on}, {v[6], v[4:2]});
      chk(ramp_uv, RAMP_TBL[i]);
      chk(sw_on, v[5]);
    end
    wr(8'h01, 8'h2a);
    for (int i = 0; i < 32; i++) begin
      {mode_sync, mode_hi, ov_lock, tshut, en_pin} = i[4:0];
      repeat (6) @(negedge clock);
      chk(sw_on, i[0] & ~i[1] & ~i[2]);
      chk(fpwm_on, i[3] | i[4]);
    end
    {mode_sync, mode_hi, ov_lock, tshut, en_pin} = 5'h01;
    for (int r = 0; r < 4; r++) begin
      rnd = lfsr(rnd);
      v = rnd[7:0];
      wr(8'h02, {4'h0, r[1:0], 2'h1});
      wr(8'h00, v);
      chk({vrange, sst, sp_code}, {r[1:0], 2'h1, v});
      chk(tgt_uv, (r == 3 ? 22'h0c3500 : 22'h061a80) + v * STEP_TBL[r]);
    end
    rnd = lfsr(rnd);
    wr(8'h05, rnd[15:8]);
    exp_q = '{8'h00, 8'h00, v, 8'h2a, 8'h0d};
    rd(8'h05, 1);
    rd(8'h07, 1);
    rd(8'h00, 3);
    // status flags are sticky and clear once read
    ev = rnd[21:16];
    repeat (4) @(negedge clock);
    exp_q = '{{2'h0, ev}, 8'h00};
    ev = 6'h00;
    rd(8'h04, 1);
    rd(8'h04, 1);
    n0 = n_start;
    wr(8'h01, {1'b1, rnd[6:0]});
    repeat (50) @(negedge clock);
    chk(n_start, n0 + 1);
    dflt(8'h40);
    wr(8'h01, 8'h55);
    strap = 2'h2;
    sup_low = 1'b1;
    repeat (8) @(negedge clock);
    sup_low = 1'b0;
    repeat (10) @(negedge clock);
    chk(n_start, n0 + 2);
    dev_addr = 7'h42;
    dflt(8'h80);
    end_of_test();
  end
endmodule // tb
